// ==== core/csrb_charger_smbus_register_bank.sv ====
`timescale 1ns/10ps
module csrb_charger_smbus_register_bank
   import csrb_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic             scl_i,
   input  wire logic             sda_i,
   output logic                  sda_o,
   output logic                  sda_oe_o,
   output logic                  alert_o,
   output logic                  alert_oe_o,
   input  wire logic             adapter_det_i,
   output logic                  adapter_sel_o,
   output logic                  battery_sel_o,
   output csrb_pkg::csrb_cfg_s   chg_cfg_o
);
   import csrb_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_RX, S_RXACK, S_TX, S_TXACK, S_TXNEXT} csrb_st_e;

   // charge voltage word to range and per-cell code
   function automatic csrb_vdec_s volt_decode(input logic [15:0] w);
      int         v;
      int         c;
      csrb_vdec_s d;
      v = int'(w & VCHG_MASK);
      c = 0;
      d.rng = RNG_OFF;
      if (v >= V_4C_LO)
      begin
         d.rng = RNG_4C;
         c = (v - V_4C_LO) / V_4C_STEP;
      end
      else if (v >= V_3C_LO && v <= V_3C_HI)
      begin
         d.rng = RNG_3C;
         c = ((v - V_3C_LO) * 4) / 75;                    // 18.75 mV step
      end
      else if (v == V_PRE)
         d.rng = RNG_PRE;
      if (c > V_CODE_MAX)
         c = V_CODE_MAX;                                  // top clamps
      d.code = (d.rng == RNG_PRE) ? V_PRE_CODE : c[6:0];
      return d;
   endfunction

   // current word field, shared by both current registers
   function automatic logic [7:0] cur_code(input logic [15:0] w);
      return w[CUR_MSB:CUR_LSB];
   endfunction

   // pin synchronisers: scl, sda, adapter detect
   logic [2:0] sy1_reg, sy2_reg, sy3_reg, filt_reg, prev_reg;
   logic [2:0] filt_next;

   // a level counts once stages two and three agree
   always_comb
   begin
      for (int i = 0; i < 3; i++)
         filt_next[i] = (sy2_reg[i] == sy3_reg[i]) ? sy3_reg[i] : filt_reg[i];
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sy1_reg  <= 3'h3;
         sy2_reg  <= 3'h3;
         sy3_reg  <= 3'h3;
         filt_reg <= 3'h3;
         prev_reg <= 3'h3;
      end
      else if (ce_i)
      begin
         sy1_reg  <= {adapter_det_i, sda_i, scl_i};
         sy2_reg  <= sy1_reg;
         sy3_reg  <= sy2_reg;
         filt_reg <= filt_next;
         prev_reg <= filt_reg;
      end
   end

   logic scl_rise, scl_fall, bus_start, bus_stop, sda_f, adp_det;
   assign scl_rise  = filt_reg[0] & ~prev_reg[0];
   assign scl_fall  = ~filt_reg[0] & prev_reg[0];
   assign bus_start = filt_reg[0] & prev_reg[0] & prev_reg[1] & ~filt_reg[1];
   assign bus_stop  = filt_reg[0] & prev_reg[0] & ~prev_reg[1] & filt_reg[1];
   assign sda_f     = filt_reg[1];
   assign adp_det   = filt_reg[2];

   // register file state
   logic [15:0] mode_reg, ichg_reg, vchg_reg, iin_reg, stat_reg;
   logic [15:0] mode_next, ichg_next, vchg_next, iin_next, stat_next;
   logic        alert_reg, alert_next;
   csrb_cfg_s   cfg_reg, cfg_next;

   // bus engine state
   csrb_st_e    st_reg, st_next;
   logic [3:0]  bc_reg, bc_next;
   logic [7:0]  sh_reg, sh_next, cmd_reg, cmd_next, lo_reg, lo_next;
   logic [1:0]  idx_reg, idx_next;
   logic        rw_reg, rw_next, drv_reg, drv_next, hi_reg, hi_next;
   logic        wr_pulse, rd_done;
   logic [15:0] rd_word;

   // read mux, unmapped commands read as zero
   always_comb
   begin
      unique case (cmd_reg)
         REG_MODE: rd_word = mode_reg;
         REG_STAT: rd_word = stat_reg;
         REG_ICHG: rd_word = ichg_reg;
         REG_VCHG: rd_word = vchg_reg;
         REG_IIN:  rd_word = iin_reg;
         default:  rd_word = 16'h0000;
      endcase
   end

   // byte engine: write-word and read-word, low byte first
   always_comb
   begin
      st_next  = st_reg;
      bc_next  = bc_reg;
      sh_next  = sh_reg;
      cmd_next = cmd_reg;
      lo_next  = lo_reg;
      idx_next = idx_reg;
      rw_next  = rw_reg;
      drv_next = drv_reg;
      hi_next  = hi_reg;
      wr_pulse = 1'b0;
      rd_done  = 1'b0;
      if (bus_start)
      begin
         st_next  = S_RX;                                 // repeated start too
         bc_next  = 4'h0;
         idx_next = 2'h0;
         drv_next = 1'b0;
      end
      else if (bus_stop)
      begin
         st_next  = S_IDLE;
         drv_next = 1'b0;
      end
      else
      begin
         unique case (st_reg)
            S_IDLE: ;
            S_RX:
            begin
               if (scl_rise)
               begin
                  sh_next = {sh_reg[6:0], sda_f};
                  bc_next = bc_reg + 4'h1;
               end
               else if (scl_fall && bc_reg == 4'h8)
               begin
                  bc_next  = 4'h0;
                  st_next  = S_RXACK;
                  drv_next = 1'b1;
                  if (idx_reg != 2'h3)
                     idx_next = idx_reg + 2'h1;
                  unique case (idx_reg)
                     2'h0:
                     begin
                        rw_next = sh_reg[0];
                        if (sh_reg[7:1] != SLAVE_ADDR7)
                        begin
                           st_next  = S_IDLE;             // not ours, stay silent
                           drv_next = 1'b0;
                        end
                     end
                     2'h1: cmd_next = sh_reg;
                     2'h2: lo_next = sh_reg;
                     2'h3: wr_pulse = 1'b1;               // no check byte expected
                  endcase
               end
            end
            S_RXACK:
            begin
               if (scl_fall)
               begin
                  drv_next = 1'b0;
                  st_next  = S_RX;
                  if (rw_reg)
                  begin
                     st_next  = S_TX;
                     sh_next  = rd_word[7:0];
                     hi_next  = 1'b0;
                     drv_next = ~rd_word[7];
                  end
               end
            end
            S_TX:
            begin
               if (scl_fall)
               begin
                  if (bc_reg == 4'h7)
                  begin
                     st_next  = S_TXACK;
                     bc_next  = 4'h0;
                     drv_next = 1'b0;
                  end
                  else
                  begin
                     sh_next  = {sh_reg[6:0], 1'b0};
                     drv_next = ~sh_reg[6];
                     bc_next  = bc_reg + 4'h1;
                  end
               end
            end
            S_TXACK:
            begin
               if (scl_rise)
               begin
                  if (hi_reg)
                  begin
                     rd_done = (cmd_reg == REG_STAT);     // read of status is complete
                     st_next = S_IDLE;                    // no third byte
                  end
                  else if (sda_f)
                     st_next = S_IDLE;                    // host gave up after one byte
                  else
                     st_next = S_TXNEXT;
               end
            end
            S_TXNEXT:
            begin
               if (scl_fall)
               begin
                  st_next  = S_TX;
                  sh_next  = rd_word[15:8];
                  hi_next  = 1'b1;
                  drv_next = ~rd_word[15];
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_reg  <= S_IDLE;
         bc_reg  <= 4'h0;
         sh_reg  <= 8'h00;
         cmd_reg <= 8'h00;
         lo_reg  <= 8'h00;
         idx_reg <= 2'h0;
         rw_reg  <= 1'b0;
         drv_reg <= 1'b0;
         hi_reg  <= 1'b0;
      end
      else if (ce_i)
      begin
         st_reg  <= st_next;
         bc_reg  <= bc_next;
         sh_reg  <= sh_next;
         cmd_reg <= cmd_next;
         lo_reg  <= lo_next;
         idx_reg <= idx_next;
         rw_reg  <= rw_next;
         drv_reg <= drv_next;
         hi_reg  <= hi_next;
      end
   end

   // registers, decode, source selection and alert
   // settings only change on host writes; no timeout clears them
   always_comb
   begin
      csrb_vdec_s vd;
      logic       adp_conn;
      vd        = volt_decode(vchg_reg);
      mode_next = mode_reg;
      ichg_next = ichg_reg;
      vchg_next = vchg_reg;
      iin_next  = iin_reg;
      if (wr_pulse)
      begin
         unique case (cmd_reg)
            REG_MODE: mode_next = {sh_reg, lo_reg};
            REG_ICHG: ichg_next = {sh_reg, lo_reg};
            REG_VCHG: vchg_next = {sh_reg, lo_reg};
            REG_IIN:  iin_next  = {sh_reg, lo_reg};
            default: ;                                    // status and unmapped ignore writes
         endcase
      end
      // learn mode overrides an attached adapter
      adp_conn  = adp_det & ~mode_reg[MODE_LEARN];
      stat_next = 16'h0000;
      stat_next[STAT_ADPT]   = adp_conn;
      stat_next[STAT_BATT]   = ~adp_conn;
      // zero setpoint is the reset default, not a fault
      stat_next[STAT_VFAULT] = (vd.rng == RNG_OFF) && (vchg_reg != 16'h0000);
      cfg_next.rng   = vd.rng;
      cfg_next.vcode = vd.code;
      cfg_next.pack_current_converter_code   = cur_code(ichg_reg);
      cfg_next.supply_current_converter_code = cur_code(iin_reg);
      // status reads never gate charging
      cfg_next.chg_en = (vd.rng != RNG_OFF)
                        && (cur_code(ichg_reg) != 8'h00)
                        && (cur_code(iin_reg) != 8'h00);
      // a change in the same cycle as the read wins
      alert_next = (stat_next != stat_reg) | (alert_reg & ~rd_done);
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mode_reg  <= MODE_RST;
         ichg_reg  <= ICHG_RST;
         vchg_reg  <= VCHG_RST;
         iin_reg   <= IIN_RST;
         stat_reg  <= 16'h0000;
         alert_reg <= 1'b0;
         cfg_reg   <= '0;
      end
      else if (ce_i)
      begin
         mode_reg  <= mode_next;
         ichg_reg  <= ichg_next;
         vchg_reg  <= vchg_next;
         iin_reg   <= iin_next;
         stat_reg  <= stat_next;
         alert_reg <= alert_next;
         cfg_reg   <= cfg_next;
      end
   end

   // open-drain pins only ever pull low
   assign sda_o         = 1'b0;
   assign sda_oe_o      = drv_reg;
   assign alert_o       = 1'b0;
   assign alert_oe_o    = alert_reg;
   assign adapter_sel_o = stat_reg[STAT_ADPT];
   assign battery_sel_o = stat_reg[STAT_BATT];
   assign chg_cfg_o     = cfg_reg;

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_ALERT_ON_CHANGE: assert property (ce_i && $changed(stat_reg) |-> alert_reg)
      else $error("status changed without alert");
   AST_ALERT_HOLD: assert property (ce_i && alert_reg && !rd_done && stat_next == stat_reg
                                    |=> alert_reg)
      else $error("alert dropped without status read");
   AST_ALERT_CLEAR: assert property (ce_i && rd_done && stat_next == stat_reg |=> !alert_oe_o)
      else $error("alert not released after status read");
   AST_ADDR_MATCH: assert property (ce_i && st_reg == S_RX && idx_reg == 2'h0 && drv_next
                                    |-> sh_reg[7:1] == SLAVE_ADDR7)
      else $error("acknowledged a foreign address");
   AST_NO_THIRD_BYTE: assert property (ce_i && st_reg == S_TXACK && hi_reg && scl_rise && !bus_start
                                       && !bus_stop |=> st_reg == S_IDLE)
      else $error("read continued past the high byte");
   AST_VOLT_CLAMP: assert property (ce_i && int'(vchg_reg & VCHG_MASK) >= 19200
                                    |=> cfg_reg.vcode == 7'h7f && cfg_reg.rng == RNG_4C)
      else $error("high voltage not clamped to top code");
   AST_VOLT_FAULT: assert property (ce_i && stat_reg[STAT_VFAULT]
                                    |-> !cfg_reg.chg_en && (!$rose(stat_reg[STAT_VFAULT]) || alert_reg))
      else $error("fault flag with charging enabled");
   AST_ZERO_CURRENT: assert property (ce_i && cur_code(ichg_reg) == 8'h00 && $stable(ichg_reg)
                                      |=> !cfg_reg.chg_en)
      else $error("zero current left charging enabled");
   AST_LEARN_SWAP: assert property (ce_i && adp_det && mode_reg[MODE_LEARN] && $stable(mode_reg)
                                    |=> !ce_i || (battery_sel_o && !adapter_sel_o))
      else $error("learn mode did not select battery");
   AST_VOLT_WRITE: assert property (ce_i && wr_pulse && cmd_reg == REG_VCHG
                                    |=> vchg_reg == {$past(sh_reg), $past(lo_reg)})
      else $error("charge voltage write lost");
endmodule

// ==== core/csrb_pkg.sv ====
package csrb_pkg;
   // bus addressing, 8-bit form 0x12 carries 7-bit address 0x09
   localparam logic [7:0] SLAVE_ADDR8 = 8'h12;
   localparam logic [6:0] SLAVE_ADDR7 = SLAVE_ADDR8[7:1];
   // register offsets (command byte)
   localparam logic [7:0] REG_MODE  = 8'h12;
   localparam logic [7:0] REG_STAT  = 8'h13;
   localparam logic [7:0] REG_ICHG  = 8'h14;
   localparam logic [7:0] REG_VCHG  = 8'h15;
   localparam logic [7:0] REG_IIN   = 8'h3f;
   // reset values
   localparam logic [15:0] MODE_RST = 16'h0000;
   localparam logic [15:0] ICHG_RST = 16'h0000;
   localparam logic [15:0] VCHG_RST = 16'h0000;
   localparam logic [15:0] IIN_RST  = 16'h0000;
   // field layout
   localparam logic [15:0] VCHG_MASK   = 16'h7ffe;
   localparam int          CUR_LSB     = 7;
   localparam int          CUR_MSB     = 14;
   localparam int          MODE_LEARN  = 0;
   localparam int          STAT_VFAULT = 4;
   localparam int          STAT_BATT   = 6;
   localparam int          STAT_ADPT   = 7;
   // voltage decode bounds in mV
   localparam int V_PRE     = 9000;
   localparam int V_3C_LO   = 12000;
   localparam int V_3C_HI   = 14400;
   localparam int V_4C_LO   = 16000;
   localparam int V_4C_STEP = 25;
   localparam int V_CODE_MAX = 127;
   localparam logic [6:0] V_PRE_CODE = 7'h00;

   typedef enum logic [1:0] {RNG_OFF, RNG_PRE, RNG_3C, RNG_4C} csrb_rng_e;

   // settings handed to the regulation loops
   typedef struct packed {
      logic       chg_en;
      csrb_rng_e  rng;
      logic [6:0] vcode;
      logic [7:0] pack_current_converter_code;
      logic [7:0] supply_current_converter_code;
   } csrb_cfg_s;

   typedef struct packed {
      csrb_rng_e  rng;
      logic [6:0] code;
   } csrb_vdec_s;
endpackage

// ==== sim/csrb_smbus_host.sv ====
`timescale 1ns/10ps
// bus master standing in for the host controller, open drain on the data line, scl driven directly
module csrb_smbus_host
   import csrb_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_pull_o
);
   // idle bus: both lines released
   initial
   begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // one 125 ns bit: data moves only while scl is low
   task automatic bit_io(input logic b, output logic rb);
      sda_pull_o <= ~b;
      tick(6);
      scl_o <= 1'b1;
      tick(12);
      rb = sda_i;
      scl_o <= 1'b0;
      tick(7);
   endtask

   // serves as start and as repeated start
   task automatic start_cond();
      sda_pull_o <= 1'b0;
      tick(6);
      scl_o <= 1'b1;
      tick(12);
      sda_pull_o <= 1'b1;
      tick(12);
      scl_o <= 1'b0;
      tick(7);
   endtask

   task automatic stop_cond();
      sda_pull_o <= 1'b1;
      tick(6);
      scl_o <= 1'b1;
      tick(12);
      sda_pull_o <= 1'b0;
      tick(12);
   endtask

   task automatic byte_out(input logic [7:0] b, output logic ack);
      logic rb;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], rb);
      bit_io(1'b1, rb);
      ack = (rb === 1'b0);
   endtask

   task automatic byte_in(input logic more, output logic [7:0] d);
      logic rb;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(~more, rb);
   endtask

   // low byte first, no check byte appended
   task automatic write_word(input logic [7:0] a8, input logic [7:0] cmd, input logic [15:0] w,
                             output logic ok);
      logic a0, a1, a2, a3;
      start_cond();
      byte_out(a8, a0);
      byte_out(cmd, a1);
      byte_out(w[7:0], a2);
      byte_out(w[15:8], a3);
      stop_cond();
      ok = a0 & a1 & a2 & a3;
   endtask

   // nack on the high byte ends the read, no check byte expected
   task automatic read_word(input logic [7:0] cmd, output logic [15:0] w, output logic ok);
      logic a0, a1, a2;
      start_cond();
      byte_out({SLAVE_ADDR7, 1'b0}, a0);
      byte_out(cmd, a1);
      start_cond();
      byte_out({SLAVE_ADDR7, 1'b1}, a2);
      byte_in(1'b1, w[7:0]);
      byte_in(1'b0, w[15:8]);
      stop_cond();
      ok = a0 & a1 & a2;
   endtask
endmodule

// ==== sim/csrb_charger_smbus_register_bank_tb.sv ====
`timescale 1ns/10ps
module csrb_charger_smbus_register_bank_tb;
   import csrb_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce_i = 1'b1;
   logic        adapter_det_i = 1'b0;
   logic        scl, host_pull, sda_o, sda_oe, alert_o, alert_oe, adp_sel, bat_sel, ok, flag, nf;
   logic [15:0] rd;
   csrb_cfg_s   cfg;
   csrb_vdec_s  e;
   int          err_count = 0;
   int          n_compared = 0;
   logic [15:0] vtab [11] = '{16'd9000, 16'd12000, 16'd12019, 16'd12038, 16'd14400, 16'd15000,
                               16'd11000, 16'd16001, 16'hbeb2, 16'd19200, 16'd20000};
   // pull-up on the data line, any party may pull it low
   wire         sda_line = ~(host_pull | (sda_oe & ~sda_o));

   always #2.5 clk_i = ~clk_i;

   csrb_charger_smbus_register_bank u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .scl_i(scl), .sda_i(sda_line),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .alert_o(alert_o), .alert_oe_o(alert_oe),
      .adapter_det_i(adapter_det_i), .adapter_sel_o(adp_sel), .battery_sel_o(bat_sel),
      .chg_cfg_o(cfg)
   );

   csrb_smbus_host u_host (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_pull_o(host_pull));

   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // sample a little after the edge so outputs have settled
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic wr(input logic [7:0] cmd, input logic [15:0] w);
      u_host.write_word(SLAVE_ADDR8, cmd, w, ok);
      check(16'(ok), 16'h0001, "write ack");
      wait_clk(4);
   endtask

   task automatic rdw(input logic [7:0] cmd);
      u_host.read_word(cmd, rd, ok);
      check(16'(ok), 16'h0001, "read ack");
      wait_clk(4);
   endtask

   // expected range and code, truncating, clamped at the top code
   function automatic csrb_vdec_s vexp(input logic [15:0] w);
      int v;
      int c;
      v = int'(w & VCHG_MASK);
      c = 0;
      vexp.rng = RNG_OFF;
      if (v >= V_4C_LO)
      begin
         vexp.rng = RNG_4C;
         c = (v - V_4C_LO) / V_4C_STEP;
      end
      else if (v >= V_3C_LO && v <= V_3C_HI)
      begin
         vexp.rng = RNG_3C;
         c = (v - V_3C_LO) * 4 / 75;
      end
      else if (v == V_PRE)
         vexp.rng = RNG_PRE;
      vexp.code = (c > V_CODE_MAX) ? 7'(V_CODE_MAX) : 7'(c);
   endfunction

   // hang guard, well beyond the expected run length
   initial
   begin
      repeat (90000) @(posedge clk_i);
      err_count++;
      print_verdict();
   end

   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_clk(10);
      check(16'(alert_oe), 16'h0001, "alert after reset");
      check(16'(bat_sel), 16'h0001, "battery on system");
      check(16'(cfg.chg_en), 16'h0000, "charger off");
      rdw(REG_VCHG);
      check(rd, VCHG_RST, "voltage reset");
      rdw(REG_ICHG);
      check(rd, ICHG_RST, "current reset");
      rdw(REG_IIN);
      check(rd, IIN_RST, "input current reset");
      rdw(REG_STAT);
      check(16'(rd[STAT_BATT]), 16'h0001, "battery bit");
      check(16'(alert_oe), 16'h0000, "alert cleared");
      $display("reset test done");
      wr(REG_ICHG, 16'h0480);
      check(16'(cfg.pack_current_converter_code), 16'h0009, "charge current code");
      wr(REG_IIN, 16'hff80);
      check(16'(cfg.supply_current_converter_code), 16'h00ff, "input current code");
      flag = 1'b0;
      foreach (vtab[i])
      begin
         e = vexp(vtab[i]);
         nf = (e.rng == RNG_OFF) && ((vtab[i] & VCHG_MASK) != 16'h0000);
         wr(REG_VCHG, vtab[i]);
         check(16'(cfg.rng), 16'(e.rng), "range");
         if (e.rng != RNG_OFF)
            check(16'(cfg.vcode), 16'(e.code), "code");
         check(16'(cfg.chg_en), 16'(e.rng != RNG_OFF), "enable");
         if (nf != flag)
            check(16'(alert_oe), 16'h0001, "alert on fault");
         rdw(REG_STAT);
         check(16'(rd[STAT_VFAULT]), 16'(nf), "fault flag");
         check(16'(alert_oe), 16'h0000, "alert after read");
         flag = nf;
      end
      $display("voltage test done");
      wr(REG_ICHG, 16'h007f);
      check(16'(cfg.chg_en), 16'h0000, "zero current");
      wr(REG_ICHG, 16'h0480);
      wr(REG_IIN, 16'h0000);
      check(16'(cfg.chg_en), 16'h0000, "zero input current");
      wr(REG_IIN, 16'hff80);
      u_host.write_word(8'h14, REG_ICHG, 16'h0000, ok);
      wait_clk(4);
      check(16'(ok), 16'h0000, "foreign address");
      check(16'(cfg.pack_current_converter_code), 16'h0009, "untouched");
      $display("current test done");
      @(posedge clk_i);
      adapter_det_i <= 1'b1;
      wait_clk(12);
      check({14'h0, adp_sel, bat_sel}, 16'h0002, "adapter on");
      check(16'(alert_oe), 16'h0001, "source alert");
      check(16'(cfg.chg_en), 16'h0001, "runs with alert");
      rdw(REG_STAT);
      check(16'(rd[STAT_ADPT:STAT_BATT]), 16'h0002, "source bits");
      wr(REG_MODE, 16'h0001 << MODE_LEARN);
      check({14'h0, adp_sel, bat_sel}, 16'h0001, "learn mode");
      rdw(REG_STAT);
      check(16'(rd[STAT_ADPT:STAT_BATT]), 16'h0001, "learn bits");
      wr(REG_MODE, 16'h0000);
      wr(REG_STAT, 16'hffff);
      rdw(REG_STAT);
      check(16'({rd[STAT_ADPT:STAT_BATT], rd[STAT_VFAULT]}), 16'h0004, "status kept");
      @(posedge clk_i);
      ce_i <= 1'b0;
      adapter_det_i <= 1'b0;
      // enable low must freeze the synchronisers and the selector
      wait_clk(12);
      check({14'h0, adp_sel, bat_sel}, 16'h0002, "frozen while disabled");
      @(posedge clk_i);
      ce_i <= 1'b1;
      wait_clk(12);
      check({14'h0, adp_sel, bat_sel}, 16'h0001, "adapter gone");
      $display("selector test done");
      // long quiet spell: settings must not decay without host traffic
      wait_clk(20000);
      check(16'(cfg.chg_en), 16'h0001, "still enabled");
      check(16'(cfg.vcode), 16'(V_CODE_MAX), "still set");
      $display("persistence test done");
      print_verdict();
   end
endmodule
